// >>> rtl/scp_port.sv
// serial configuration port: frame decoder, shifter and pin drivers
// assumes sclk, enable and data pins are asynchronous to mclk and that
// sclk is slow enough (well under mclk/4) for edge finding by sampling
`timescale 1ns/100ps
`include "scp_cfg.svh"
// What this block does
// - three or four wire mode by config bit
// - three wire: data pin both ways
// - four wire: read data on output pin
// - incoming bits sampled on rising serial clock
// - read bits change on falling serial clock
// - first byte is instruction: read or write
// - instruction carries seven bit register address
// - flag at top, address below it
// - data phase is exactly two bytes
// - every mode register readable and writable
// - flag one reads, flag zero writes
// - three wire read keeps output pin released until the final falling edge
// - pins low after read, released at enable
module scp_port (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // serial link pins
  input  wire logic sclk,
  input  wire logic serial_frame_enable_n,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      serial_data_out_pin,
  output logic      sdo_oe,
  // mode seen by the rest of the device
  output logic      four_wire_select
);
  import scp_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic en_s1_q, en_s2_q;
  logic sdi_s1_q, sdi_s2_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      en_s1_q   <= 1'b1;
      en_s2_q   <= 1'b1;
      sdi_s1_q  <= 1'b0;
      sdi_s2_q  <= 1'b0;
    end else begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      en_s1_q   <= serial_frame_enable_n;
      en_s2_q   <= en_s1_q;
      sdi_s1_q  <= sdio_in;
      sdi_s2_q  <= sdi_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  scp_state_t state_q, state_d;
  logic [4:0] bit_cnt_q;
  scp_word_t  shin_q;
  scp_word_t  shout_q;
  scp_addr_t  addr_q;
  logic       rw_q;
  logic       wr_en_q;
  logic       sdio_out_q, sdio_oe_q, sdo_out_q, sdo_oe_q;
  scp_word_t  rd_data;

  // data and enable share the clock's sync delay, so alignment holds
  wire       sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire       sclk_fall = ~sclk_s2_q & sclk_s3_q;
  wire       frame_on  = ~en_s2_q;
  wire       in_instr  = (state_q == SCP_IDLE) || (state_q == SCP_INSTR);
  wire       shift_en  = sclk_rise && frame_on && (state_q != SCP_DONE);
  wire [7:0] instr_w   = {shin_q[6:0], sdi_s2_q};
  wire       instr_end = shift_en && in_instr &&
                         (bit_cnt_q == `SCP_INSTR_LAST);
  wire       frame_end = shift_en && (state_q == SCP_DATA) &&
                         (bit_cnt_q == `SCP_FRAME_LAST);
  wire       is_read_w = instr_w[`SCP_RW_BIT] == `SCP_RW_READ;
  wire       rd_phase  = (state_q == SCP_DATA) && rw_q;
  wire       drive_bit = sclk_fall && frame_on && rd_phase;
  wire       drive_low = sclk_fall && frame_on &&
                         (state_q == SCP_DONE) && rw_q;
  wire       wr_go     = frame_end && !rw_q;
  wire       out_bit   = shout_q[15];
  // address taken from the seven bits under the flag
  wire scp_addr_t rd_addr = instr_w[6:0];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SCP_IDLE:  if (frame_on) state_d = SCP_INSTR;
      SCP_INSTR: if (instr_end) state_d = SCP_DATA;
      SCP_DATA:  if (frame_end) state_d = SCP_DONE;
      SCP_DONE:  state_d = SCP_DONE;
    endcase
    if (instr_end) begin
      state_d = SCP_DATA;
    end
    // enable released: any frame in flight is dropped
    if (!frame_on) begin
      state_d = SCP_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // frame state and shifters
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= SCP_IDLE;
      bit_cnt_q <= 5'h00;
      shin_q    <= 16'h0000;
    end else begin
      state_q   <= state_d;
      if (!frame_on) begin
        bit_cnt_q <= 5'h00;
      end else if (shift_en) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
        shin_q    <= {shin_q[14:0], sdi_s2_q};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rw_q    <= 1'b0;
      addr_q  <= 7'h00;
      shout_q <= 16'h0000;
    end else if (instr_end) begin
      rw_q    <= is_read_w;
      addr_q  <= rd_addr;
      shout_q <= rd_data;
    end else if (drive_bit) begin
      shout_q <= {shout_q[14:0], 1'b0};
    end
  end

  // write lands only after the 24th bit of a complete frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_q <= 1'b0;
    end else begin
      wr_en_q <= wr_go;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sdio_out_q <= 1'b0;
      sdio_oe_q  <= 1'b0;
      sdo_out_q  <= 1'b0;
      sdo_oe_q   <= 1'b0;
    end else if (!frame_on) begin
      sdio_out_q <= 1'b0;
      sdio_oe_q  <= 1'b0;
      sdo_out_q  <= 1'b0;
      sdo_oe_q   <= 1'b0;
    end else if (drive_bit) begin
      sdio_out_q <= out_bit & ~four_wire_select;
      sdio_oe_q  <= ~four_wire_select;
      sdo_out_q  <= out_bit & four_wire_select;
      sdo_oe_q   <= four_wire_select;
    end else if (drive_low) begin
      sdio_out_q <= 1'b0;
      sdio_oe_q  <= 1'b1;
      sdo_out_q  <= 1'b0;
      sdo_oe_q   <= 1'b1;
    end
  end

  assign sdio_out            = sdio_out_q;
  assign sdio_oe             = sdio_oe_q;
  assign serial_data_out_pin = sdo_out_q;
  assign sdo_oe              = sdo_oe_q;

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  scp_regfile u_regfile (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .wr_en            (wr_en_q),
    .wr_addr          (addr_q),
    .wr_data          (shin_q),
    .rd_addr          (rd_addr),
    .rd_data          (rd_data),
    .four_wire_select (four_wire_select)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_read_end;
    drive_low ##1 (!sdio_out_q && !sdo_out_q && sdio_oe_q && sdo_oe_q);
  endsequence

  sequence s_released;
    ##1 (!sdio_oe_q && !sdo_oe_q && !sdio_out_q && !sdo_out_q);
  endsequence

  four_wire_pins_a: assert property (
    sdo_oe_q && !sdio_oe_q |-> $past(four_wire_select))
    else $error("output pin driven outside four wire mode");

  three_wire_pins_a: assert property (
    drive_bit && !four_wire_select |=> sdio_oe_q && !sdo_oe_q)
    else $error("three wire read did not use data pin alone");

  out_on_fall_a: assert property (
    $changed(sdio_out_q) && frame_on |-> $past(sclk_fall))
    else $error("read bit changed away from falling edge");

  read_end_low_a: assert property (
    drive_low |-> s_read_end)
    else $error("pins not low after final falling edge");

  release_pins_a: assert property (
    $rose(en_s2_q) |-> s_released)
    else $error("pins not released when enable rose");

  instr_len_a: assert property (
    state_q == SCP_INSTR && state_d == SCP_DATA |->
      bit_cnt_q == 5'h07 && sclk_rise)
    else $error("data phase began before eight instruction bits");

  write_len_a: assert property (
    wr_en_q |-> $past(bit_cnt_q) == 5'h17 && !rw_q &&
                $past(state_q) == SCP_DATA)
    else $error("write strobe without a full frame");

  abort_nowrite_a: assert property (
    !frame_on && state_q != SCP_DONE |=> !wr_en_q)
    else $error("short frame wrote a register");

  // the flag is the first bit shifted, so at the last instruction bit it sits in shin_q[6]
  rw_decode_a: assert property (
    instr_end |=> rw_q == $past(shin_q[6]) ##0
                  addr_q == $past({shin_q[5:0], sdi_s2_q}))
    else $error("read flag or address decoded wrongly");

  msb_first_a: assert property (
    drive_bit |=> (sdio_out_q | sdo_out_q) == $past(shout_q[15]))
    else $error("read data not msb first");
endmodule

// >>> rtl/scp_cfg.svh
// constants of the serial configuration port
// assumes inclusion by bare name from the rtl files
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define SCP_INSTR_LAST   5'h07
`define SCP_FRAME_LAST   5'h17
`define SCP_RW_BIT       7
`define SCP_RW_READ      1'b1
// ----------------------------------------------------------------------
// register file
// ----------------------------------------------------------------------
`define SCP_REG_COUNT    128
`define SCP_REG_RESET    16'h0000
`define SCP_CFG_TWO_IDX  7'h02
`define SCP_FOUR_WIRE_BIT 7
`endif

// >>> rtl/scp_pkg.sv
// types shared by the serial configuration port files
// assumes scp_cfg.svh holds the numeric constants
package scp_pkg;
  typedef logic [6:0]  scp_addr_t;
  typedef logic [15:0] scp_word_t;
  typedef enum logic [1:0] {
    SCP_IDLE  = 2'h0,
    SCP_INSTR = 2'h1,
    SCP_DATA  = 2'h3,
    SCP_DONE  = 2'h2
  } scp_state_t;
endpackage

// >>> rtl/scp_regfile.sv
// mode register storage of the serial configuration port
// assumes one write strobe per frame from the port, same clock
`timescale 1ns/100ps
`include "scp_cfg.svh"
module scp_regfile (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // write side
  input  wire logic              wr_en,
  input  wire scp_pkg::scp_addr_t wr_addr,
  input  wire scp_pkg::scp_word_t wr_data,
  // read side
  input  wire scp_pkg::scp_addr_t rd_addr,
  output scp_pkg::scp_word_t     rd_data,
  // mode bit
  output logic                   four_wire_select
);
  import scp_pkg::*;
  scp_word_t regs_q [`SCP_REG_COUNT];
  // ----------------------------------------------------------------------
  // one word per address, each both writable and readable
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SCP_REG_COUNT; gi = gi + 1) begin : g_reg
      wire hit = wr_en && (wr_addr == 7'(gi));
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[gi] <= `SCP_REG_RESET;
        end else if (hit) begin
          regs_q[gi] <= wr_data;
        end
      end
    end
  endgenerate
  assign rd_data = regs_q[rd_addr];
  // wire mode comes straight from the second config word
  assign four_wire_select =
    regs_q[`SCP_CFG_TWO_IDX][`SCP_FOUR_WIRE_BIT];
endmodule

// >>> testbench/scp_host.sv
// host model: serial master of the configuration port
// assumes mclk at 25 MHz; link clock made from it, 320 ns period
`timescale 1ns/100ps
module scp_host (
  // clock
  input  wire logic mclk,
  // link pins
  output logic      sclk,
  output logic      serial_frame_enable_n,
  output wire logic sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_data_out_pin,
  input  wire logic sdo_oe
);
  logic host_d;
  logic host_oe;
  logic last_q;
  // a released line toggles, so a stale bit can never look right
  assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : ~last_q);
  always @(posedge mclk) last_q <= sdio_in;
  initial begin
    sclk = 1'b0;
    serial_frame_enable_n = 1'b1;
    host_d = 1'b0;
    host_oe = 1'b0;
    last_q = 1'b0;
  end
  // ------------------------------------------------------------------
  // one frame; nbits under 24 cuts it short
  // ------------------------------------------------------------------
  task automatic xfer(input logic [7:0] ins, input logic [15:0] wd,
                      input int nbits, input logic four,
                      output logic [15:0] rd, output logic bad);
    logic [23:0] fr;
    logic        rdop;
    fr = {ins, wd};
    rdop = ins[7];
    rd = 16'h0000;
    bad = 1'b0;
    serial_frame_enable_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      sclk <= 1'b0;
      host_d <= fr[23-i];
      host_oe <= !(rdop && i > 7 && !four);
      // low for 5 cycles so read bits have settled before the rise
      repeat (5) @(posedge mclk);
      if (sdio_oe !== (rdop && i > 7 && !four)) bad = 1'b1;
      if (sdo_oe !== (rdop && i > 7 && four)) bad = 1'b1;
      if (i > 7) rd[23-i] = four ? serial_data_out_pin : sdio_in;
      sclk <= 1'b1;
      repeat (3) @(posedge mclk);
    end
    sclk <= 1'b0;
    host_oe <= 1'b0;
    repeat (5) @(posedge mclk);
    if (rdop && nbits == 24) begin
      if ({sdio_oe, sdo_oe, sdio_out, serial_data_out_pin} !== 4'hc)
        bad = 1'b1;
    end
    serial_frame_enable_n <= 1'b1;
    repeat (5) @(posedge mclk);
    if (sdio_oe !== 1'b0 || sdo_oe !== 1'b0) bad = 1'b1;
  endtask
endmodule

// >>> testbench/serial_config_port_tb.sv
// self-checking bench of the serial configuration port
// assumes scp_host as link master and scp_cfg.svh on the include path
`timescale 1ns/100ps
`include "scp_cfg.svh"
module serial_config_port_tb;
  logic        mclk;
  logic        rst_n;
  wire         sclk;
  wire         serial_frame_enable_n;
  wire         sdio_in;
  logic        sdio_out;
  logic        sdio_oe;
  logic        serial_data_out_pin;
  logic        sdo_oe;
  logic        four_wire_select;
  int          errors;
  int          checks_done;
  int          cycles;
  logic [15:0] shadow [128];
  scp_port u_scp_port (.mclk, .rst_n, .sclk, .serial_frame_enable_n,
    .sdio_in, .sdio_out, .sdio_oe, .serial_data_out_pin, .sdo_oe,
    .four_wire_select);
  scp_host u_scp_host (.mclk, .sclk, .serial_frame_enable_n, .sdio_in,
    .sdio_out, .sdio_oe, .serial_data_out_pin, .sdo_oe);
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  // ------------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hang guard: 206 cycles a full frame, some 44 frames
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      stop_test();
    end
  end
  // ------------------------------------------------------------------
  // one access, judged against the shadow copy
  // ------------------------------------------------------------------
  // expected wire mode, from the shadow copy of the config word
  function automatic logic mode_exp();
    return shadow[`SCP_CFG_TWO_IDX][`SCP_FOUR_WIRE_BIT];
  endfunction
  task automatic access(input logic [6:0] a, input logic wr,
                        input logic [15:0] d, input int nbits);
    logic [15:0] rd;
    logic        bad;
    logic        four;
    four = mode_exp();
    u_scp_host.xfer({~wr, a}, d, nbits, four, rd, bad);
    check("pin enables", 16'h0000,
      {15'h0, bad});
    if (wr && nbits == 24) shadow[a] = d;
    if (!wr) check("read word", shadow[a], rd);
    check("wire mode", {15'h0, mode_exp()},
      {15'h0, four_wire_select});
  endtask
  initial begin
    logic [6:0]  a;
    logic [15:0] d;
    int          n;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    rst_n = 1'b0;
    for (int i = 0; i < 128; i++) shadow[i] = 16'h0000;
    void'($urandom(91));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int m = 0; m < 2; m++) begin
      // address ends and extreme words, in three then four wire mode
      access(7'h00, 1'b1, 16'hffff, 24);
      access(7'h7f, 1'b1, 16'h8001, 24);
      access(7'h00, 1'b0, 16'h0000, 24);
      access(7'h7f, 1'b0, 16'h0000, 24);
      // random traffic, about one write frame in three cut short
      repeat (8) begin
        a = 7'($urandom);
        if (a == `SCP_CFG_TWO_IDX) a = 7'h03;
        d = 16'($urandom);
        n = ($urandom % 3 == 0) ? int'($urandom % 24) : 24;
        access(a, 1'b1, d, n);
        access(a, 1'b0, 16'h0000, 24);
      end
      access(`SCP_CFG_TWO_IDX, 1'b1, m ? 16'h0000 : 16'h0080, 24);
      access(`SCP_CFG_TWO_IDX, 1'b0, 16'h0000, 24);
      $display("mode pass %0d done", m);
    end
    stop_test();
  end
endmodule
